/* rtl/dpct_defs.vh */
// constants for the command-timing block of the memory device model
// assumes a single 100 MHz clock; speed grade chosen by a 2-bit port
// Summary of operation
// [RULE1] alert held low 80-160/88-176/96-192 clocks
// [RULE2] controller idles within 71/78/85 clocks persistent
// [RULE3] latency mode samples 5 or 6 clocks late
// [RULE4] gear-down latency 6 or 8 clocks
// [RULE5] controller waits exit delay before non-loop commands
// [RULE6] loop commands wait exit plus relock delay
// [RULE7] select low 12 ns to exit-minus-10 ns
// [RULE8] test enable high 200 ns before select
// [RULE9] continuity outputs valid within 200 ns
// [RULE10] clock valid, enable high 10 ns after test
// [RULE11] power-save entry disables command path after delay
// [RULE12] mode commands spaced update plus latency
`ifndef DPCT_DEFS_VH
`define DPCT_DEFS_VH
`define DPCT_CLK_PERIOD_NS 10
`define DPCT_GRADE_2666 2'h0
`define DPCT_GRADE_2933 2'h1
`define DPCT_GRADE_3200 2'h2
// alert pulse length, the minimum of each grade
`define DPCT_ALERT_PW_2666 8'h50
`define DPCT_ALERT_PW_2933 8'h58
`define DPCT_ALERT_PW_3200 8'h60
`define DPCT_ALERT_RSP_2666 8'h47
`define DPCT_ALERT_RSP_2933 8'h4E
`define DPCT_ALERT_RSP_3200 8'h55
`define DPCT_CAL_2666 4'h5
`define DPCT_CAL_HI 4'h6
`define DPCT_CALG_2666 4'h6
`define DPCT_CALG_HI 4'h8
`define DPCT_PS_DISABLE_DLY 4'h4
`define DPCT_CONT_VALID_NS 200
`define DPCT_CONT_VALID_CYC (`DPCT_CONT_VALID_NS / `DPCT_CLK_PERIOD_NS)
`define DPCT_CONT_ENABLE_NS 200
`define DPCT_CONT_ENABLE_CYC \
  ((`DPCT_CONT_ENABLE_NS + `DPCT_CLK_PERIOD_NS - 1) / `DPCT_CLK_PERIOD_NS)
`define DPCT_CONT_DELAY 5'h03
`endif

/* rtl/dpct_timing.v */
// command-timing core: parity alert pulse, cs-to-command latency,
// power-save entry and exit, continuity test response
// assumes inputs synchronous to clk_in, controller obeys its timings
`include "dpct_defs.vh"
module dpct_timing (
  // clock and reset
  input wire clk_in,
  input wire rstn_in,
  // configuration
  input wire [1:0] grade_in,
  input wire cal_mode_in,
  input wire gear_down_in,
  input wire persistent_parity_in,
  // command interface
  input wire cs_n_in,
  input wire cke_in,
  input wire [7:0] cmd_in,
  input wire parity_err_in,
  input wire max_power_saving_mode_in,
  input wire test_enable_pin_in,
  input wire [7:0] test_in,
  // outputs
  output wire alert_n_out,
  output wire cmd_valid_out,
  output wire [7:0] cmd_out,
  output wire cmd_path_on_out,
  output wire [7:0] test_out,
  output wire test_valid_out,
  output wire parity_locked_out
);

// ------------------------------------------------------------
// grade dependent figures
// ------------------------------------------------------------
reg [7:0] pw_len;
reg [3:0] lat;
always @* begin
  case (grade_in)
    `DPCT_GRADE_2666: pw_len = `DPCT_ALERT_PW_2666; // [RULE1]
    `DPCT_GRADE_2933: pw_len = `DPCT_ALERT_PW_2933; // [RULE1]
    default: pw_len = `DPCT_ALERT_PW_3200; // [RULE1]
  endcase
  if (grade_in == `DPCT_GRADE_2666) begin
    lat = gear_down_in ? `DPCT_CALG_2666 : `DPCT_CAL_2666; // [RULE4]
  end else begin
    lat = gear_down_in ? `DPCT_CALG_HI : `DPCT_CAL_HI; // [RULE3] [RULE4]
  end
end

// ------------------------------------------------------------
// max power saving entry and exit
// ------------------------------------------------------------
localparam PS_RUN = 2'h0;
localparam PS_WAIT = 2'h1;
localparam PS_SAVE = 2'h2;
reg [1:0] ps_state_reg;
reg [1:0] ps_state_next;
reg [3:0] ps_cnt_reg;
reg [3:0] ps_cnt_next;
reg path_on_reg;
reg path_on_next;
always @* begin
  ps_state_next = ps_state_reg;
  ps_cnt_next = ps_cnt_reg;
  path_on_next = path_on_reg;
  case (ps_state_reg)
    PS_RUN: begin
      if (max_power_saving_mode_in) begin
        ps_state_next = PS_WAIT;
        ps_cnt_next = `DPCT_PS_DISABLE_DLY;
      end
    end
    PS_WAIT: begin
      ps_cnt_next = ps_cnt_reg - 4'h1;
      if (ps_cnt_reg == 4'h1) begin
        ps_state_next = PS_SAVE;
        path_on_next = 1'b0; // [RULE11]
      end
    end
    PS_SAVE: begin
      // level test only: a cke already high with cs low exits too
      if (cke_in && !cs_n_in && !max_power_saving_mode_in) begin
        ps_state_next = PS_RUN; // [RULE7]
        path_on_next = 1'b1;
      end
    end
    default: begin
      ps_state_next = PS_RUN;
      path_on_next = 1'b1;
    end
  endcase
end
always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    ps_state_reg <= PS_RUN;
    ps_cnt_reg <= 4'h0;
    path_on_reg <= 1'b1;
  end else begin
    ps_state_reg <= ps_state_next;
    ps_cnt_reg <= ps_cnt_next;
    path_on_reg <= path_on_next;
  end
end

// ------------------------------------------------------------
// parity alert pulse
// ------------------------------------------------------------
reg [7:0] alert_cnt_reg;
reg [7:0] alert_cnt_next;
reg locked_reg;
reg locked_next;
// a new error during the pulse is absorbed, not restarted
always @* begin
  alert_cnt_next = alert_cnt_reg;
  locked_next = locked_reg;
  if (alert_cnt_reg != 8'h00) begin
    alert_cnt_next = alert_cnt_reg - 8'h01; // [RULE1]
  end else if (parity_err_in) begin
    alert_cnt_next = pw_len; // [RULE1]
  end
  if (parity_err_in && persistent_parity_in) begin
    locked_next = 1'b1;
  end else if (!persistent_parity_in) begin
    locked_next = 1'b0;
  end
end
always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    alert_cnt_reg <= 8'h00;
    locked_reg <= 1'b0;
  end else begin
    alert_cnt_reg <= alert_cnt_next;
    locked_reg <= locked_next;
  end
end

// ------------------------------------------------------------
// command capture with optional cs latency
// ------------------------------------------------------------
reg [3:0] lat_cnt_reg;
reg [3:0] lat_cnt_next;
reg cmd_valid_reg;
reg cmd_valid_next;
reg [7:0] cmd_reg;
reg [7:0] cmd_next;
// selects inside a countdown are dropped; the controller spaces them
always @* begin
  lat_cnt_next = lat_cnt_reg;
  cmd_valid_next = 1'b0;
  cmd_next = cmd_reg;
  if (lat_cnt_reg != 4'h0) begin
    lat_cnt_next = lat_cnt_reg - 4'h1;
    if (lat_cnt_reg == 4'h1) begin
      cmd_valid_next = path_on_reg; // [RULE3] [RULE4]
      cmd_next = cmd_in; // [RULE3] [RULE4]
    end
  end else if (!cs_n_in && path_on_reg) begin
    if (cal_mode_in) begin
      lat_cnt_next = lat; // [RULE3] [RULE4]
    end else begin
      cmd_valid_next = 1'b1;
      cmd_next = cmd_in;
    end
  end
end
always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    lat_cnt_reg <= 4'h0;
    cmd_valid_reg <= 1'b0;
    cmd_reg <= 8'h00;
  end else begin
    lat_cnt_reg <= lat_cnt_next;
    cmd_valid_reg <= cmd_valid_next;
    cmd_reg <= cmd_next;
  end
end

// ------------------------------------------------------------
// continuity test: output follows inverted inputs after short delay
// ------------------------------------------------------------
reg [4:0] cont_cnt_reg;
reg [4:0] cont_cnt_next;
reg [7:0] test_reg;
reg [7:0] test_next;
reg test_valid_reg;
reg test_valid_next;
always @* begin
  cont_cnt_next = cont_cnt_reg;
  test_next = test_reg;
  test_valid_next = test_valid_reg;
  if (!test_enable_pin_in || cs_n_in) begin
    cont_cnt_next = 5'h00;
    test_valid_next = 1'b0;
  end else begin
    // delay well under the bound; the inputs stay tracked every cycle
    if (cont_cnt_reg != `DPCT_CONT_DELAY) begin
      cont_cnt_next = cont_cnt_reg + 5'h01;
    end else begin
      test_valid_next = 1'b1; // [RULE9]
    end
    test_next = ~test_in; // [RULE9]
  end
end
always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    cont_cnt_reg <= 5'h00;
    test_reg <= 8'h00;
    test_valid_reg <= 1'b0;
  end else begin
    cont_cnt_reg <= cont_cnt_next;
    test_reg <= test_next;
    test_valid_reg <= test_valid_next;
  end
end

// ------------------------------------------------------------
// outputs
// ------------------------------------------------------------
// data straight from flip-flops; only the alert level is decoded
assign alert_n_out = (alert_cnt_reg == 8'h00); // [RULE1]
assign cmd_valid_out = cmd_valid_reg;
assign cmd_out = cmd_reg;
assign cmd_path_on_out = path_on_reg;
assign test_out = test_reg;
assign test_valid_out = test_valid_reg;
assign parity_locked_out = locked_reg;

endmodule // dpct_timing

/* test/dpct_chk.sv */
// port assertions for dpct_timing
// assumes one clock and the hand-over latencies
module dpct_chk (
  input wire clk_in, input wire rstn_in, input wire [1:0] grade_in,
  input wire cal_mode_in, input wire gear_down_in, input wire cs_n_in,
  input wire cke_in, input wire parity_err_in,
  input wire max_power_saving_mode_in, input wire test_enable_pin_in,
  input wire alert_n_out, input wire cmd_valid_out,
  input wire cmd_path_on_out, input wire test_valid_out);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  logic [7:0] pw_reg;
  always @(posedge clk_in or negedge rstn_in)
    if (!rstn_in) pw_reg <= 8'h00;
    else pw_reg <= alert_n_out ? 8'h00 : pw_reg + 8'h01;
  sequence s_cs; $fell(cs_n_in) && cmd_path_on_out && cal_mode_in; endsequence
  property p_on; parity_err_in && alert_n_out |=> !alert_n_out; endproperty
  a_on: assert property (p_on) else $error("alert late");
  property p_pw; $rose(alert_n_out) |-> pw_reg == 8'h50 + 8'h08 *
    (grade_in > 2'h1 ? 8'h02 : {6'h00, grade_in}); endproperty
  a_pw: assert property (p_pw) else $error("alert width");
  property p_c5; s_cs ##0 (grade_in == 2'h0 && !gear_down_in)
    |=> !cmd_valid_out[*5] ##1 cmd_valid_out; endproperty
  a_c5: assert property (p_c5) else $error("latency 5");
  property p_c8; s_cs ##0 (grade_in != 2'h0 && gear_down_in)
    |=> !cmd_valid_out[*8] ##1 cmd_valid_out; endproperty
  a_c8: assert property (p_c8) else $error("latency 8");
  property p_c6; s_cs ##0 (grade_in == 2'h0 ? gear_down_in : !gear_down_in)
    |=> !cmd_valid_out[*6] ##1 cmd_valid_out; endproperty
  a_c6: assert property (p_c6) else $error("latency 6");
  property p_ps; $rose(max_power_saving_mode_in) && cmd_path_on_out
    |=> cmd_path_on_out[*3] ##[1:2] !cmd_path_on_out; endproperty
  a_ps: assert property (p_ps) else $error("path off");
  property p_px; !cmd_path_on_out && cke_in && !cs_n_in &&
    !max_power_saving_mode_in |=> cmd_path_on_out; endproperty
  a_px: assert property (p_px) else $error("path on");
  property p_cont; $rose(test_enable_pin_in && !cs_n_in)
    |-> ##[1:20] test_valid_out; endproperty
  a_cont: assert property (p_cont) else $error("test late");
endmodule // dpct_chk
bind dpct_timing dpct_chk u_dpct_chk (.clk_in(clk_in), .rstn_in(rstn_in),
  .grade_in(grade_in), .cal_mode_in(cal_mode_in),
  .gear_down_in(gear_down_in), .cs_n_in(cs_n_in), .cke_in(cke_in),
  .parity_err_in(parity_err_in),
  .max_power_saving_mode_in(max_power_saving_mode_in),
  .test_enable_pin_in(test_enable_pin_in), .alert_n_out(alert_n_out),
  .cmd_valid_out(cmd_valid_out), .cmd_path_on_out(cmd_path_on_out),
  .test_valid_out(test_valid_out));

/* test/dpct_host.sv */
// controller model: one-cycle selects unless held, bus moves once the latency count ends
// assumes the device samples on the rising edge between our updates
module dpct_host (
  input wire clk_in, input wire req_in, input wire hold_in,
  input wire alert_n_in, input wire [7:0] word_in, input wire [3:0] lat_in,
  output logic cs_n_out = 1'b1, output logic [7:0] cmd_out = 8'h00);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] left = 4'h0;
  always @(negedge clk_in) begin
    cs_n_out <= !((req_in && alert_n_in) || hold_in);
    if (req_in) begin
      cmd_out <= word_in;
      left <= lat_in;
    end else if (left != 4'h0) left <= left - 4'h1;
    else cmd_out <= ~cmd_out;
  end
endmodule // dpct_host

/* test/tb.sv */
// bench for dpct_timing against a queue model
// assumes the host model drives select and command on falling edges
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 0, rstn_in = 0, cal = 0, gear = 0, cke = 1, perr = 0, pp = 0;
  logic mps = 0, tst_en = 0, req = 0, hold = 0, cs_n, alert_n, vld, path;
  logic tv, lck;
  logic [1:0] grade = 0;
  logic [3:0] lat = 0;
  logic [7:0] word = 0, tin = 0, tprev, cmd, cmdo, tout;
  int err_total = 0, cmp_count = 0, low = 0;
  logic [7:0] q[$];
  always #5 clk_in = ~clk_in;
  dpct_host u_dpct_host (.clk_in, .req_in(req), .hold_in(hold),
    .alert_n_in(alert_n), .word_in(word), .lat_in(lat), .cs_n_out(cs_n),
    .cmd_out(cmd));
  dpct_timing u_dpct_timing (.clk_in, .rstn_in, .grade_in(grade),
    .cal_mode_in(cal), .gear_down_in(gear), .persistent_parity_in(pp),
    .cs_n_in(cs_n), .cke_in(cke), .cmd_in(cmd), .parity_err_in(perr),
    .max_power_saving_mode_in(mps), .test_enable_pin_in(tst_en),
    .test_in(tin), .alert_n_out(alert_n), .cmd_valid_out(vld),
    .cmd_out(cmdo), .cmd_path_on_out(path), .test_out(tout),
    .test_valid_out(tv), .parity_locked_out(lck));
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    cmp_count++;
    if (e !== s) begin
      err_total++;
      $display("FAIL %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic results;
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk_in);
  endtask
  always @(posedge clk_in) tprev <= tin;
  always @(negedge clk_in) begin
    if (vld === 1'b1 && q.size() > 0) chk("cmd", q.pop_front(), cmdo);
    if (tv === 1'b1) chk("test", ~tprev, tout);
    if (alert_n === 1'b0) low++;
  end
  initial begin
    void'($urandom(32'hA4C9));
    cyc(6);
    rstn_in <= 1'b1;
    for (int g = 0; g < 4; g++) for (int k = 0; k < 3; k++) begin
      grade <= g[1:0];
      cal <= k > 0;
      gear <= k > 1;
      lat <= k == 0 ? 4'h0 : g == 0 ? 4'h5 + (k > 1) : 4'h6 + 4'h2 * (k > 1);
      word <= 8'($urandom);
      cyc(1);
      q.push_back(word);
      req <= 1'b1;
      cyc(1);
      req <= 1'b0;
      cyc(12);
      if (k == 0) begin
        pp <= 1'b1;
        perr <= 1'b1;
        low = 0;
        cyc(1);
        perr <= 1'b0;
        cyc(9);
        perr <= 1'b1; // refused mid-pulse
        cyc(1);
        perr <= 1'b0;
        chk("lock", 8'h01, {7'h00, lck});
        for (int i = 0; i < 300 && alert_n !== 1'b1; i++) cyc(1);
        if (alert_n !== 1'b1) begin
          err_total++;
          results();
        end
        chk("alert", 8'(80 + 8 * (g > 2 ? 2 : g)), 8'(low));
        pp <= 1'b0;
        cyc(1);
        chk("lock", 8'h00, {7'h00, lck});
      end
    end
    chk("queue", 8'h00, 8'(q.size()));
    cal <= 1'b0;
    mps <= 1'b1;
    cyc(8);
    chk("path", 8'h00, {7'h00, path});
    mps <= 1'b0;
    cke <= 1'b0;
    hold <= 1'b1;
    cyc(3);
    cke <= 1'b1;
    cyc(2);
    hold <= 1'b0;
    cyc(4);
    chk("path", 8'h01, {7'h00, path});
    tst_en <= 1'b1;
    cyc(20);
    hold <= 1'b1;
    repeat (12) @(negedge clk_in) tin <= 8'($urandom);
    chk("tvalid", 8'h01, {7'h00, tv});
    hold <= 1'b0;
    tst_en <= 1'b0;
    cyc(3);
    chk("tvalid", 8'h00, {7'h00, tv});
    results();
  end
endmodule // tb
